// ### src/pcled_ctrl.sv
// single-pin pulse-count control of a six-output led current driver
`timescale 1ns/1ps
`include "pcled_consts.svh"
// Functional notes
// - each rising pin edge advances a counter decoded into 32 current settings
// - counter is modulo 32; edge after state 32 returns to state 1
// - edges up to 1 MHz are counted; host pulses no faster
// - first edge from disabled enables and sets all currents to zero
// - current holds while pin stays high after last edge
// - pin low continuously 500 us disables; shorter lows do not
// - enabling edge starts charge pump, full capacity after soft-start
// - edges keep counting during soft-start
// - each setting holds until next edge, unless the pin stays low 500 us and disables
// - 1X mode when supply exceeds output need, else 1.5X
// - pump switching clock fixed near 1 MHz
// - group A steps 0,1,10,12,15,20 mA within each six states
// - group B 0,1,10,12,15 mA per six states, 20 mA in 31-32
// - state 31 group A is 0 mA, state 32 is 20 mA
module pcled_ctrl (
  input wire logic sys_clk, // 20 MHz clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic enSetPin, // enable/program pin from host
  input wire logic supplyAboveNeed, // comparator: supply exceeds output need
  output pcled_pkg::pcled_level_t ledLevel, // currents of both led groups
  output logic deviceEnabled, // device enabled
  output logic pumpFullCapacity, // soft-start finished
  output logic pumpDoubleMode, // high: 1.5X pump, low: 1X load switch
  output logic pumpClk // pump switching clock
);
  import pcled_pkg::*;

  localparam int TOFF_CYC = `PCLED_TOFF_CYC;
  localparam int TSS_CYC = `PCLED_TSS_CYC;
  localparam int SW_HALF = `PCLED_SW_HALF_CYC;

  function automatic logic [4:0] stepCurrent(input logic [2:0] idx);
    unique case (idx)
      3'h0: stepCurrent = `PCLED_MA_0;
      3'h1: stepCurrent = `PCLED_MA_1;
      3'h2: stepCurrent = `PCLED_MA_10;
      3'h3: stepCurrent = `PCLED_MA_12;
      3'h4: stepCurrent = `PCLED_MA_15;
      default: stepCurrent = `PCLED_MA_20;
    endcase
  endfunction

  // state index 0..31 stands for states 1..32
  function automatic pcled_level_t decodeLevel(input logic [4:0] st);
    pcled_level_t lv;
    lv.groupA = stepCurrent(3'(st % 5'd6));
    lv.groupB = stepCurrent(3'(st / 5'd6));
    if (st == 5'h1E) begin
      lv.groupA = `PCLED_MA_0;
      lv.groupB = `PCLED_MA_20;
    end else if (st == 5'h1F) begin
      lv.groupA = `PCLED_MA_20;
      lv.groupB = `PCLED_MA_20;
    end
    return lv;
  endfunction

  // the disabled phase gates most of the block
  function automatic logic isOff(input pcled_state_t st);
    return st == PCLED_OFF;
  endfunction

  logic pinMeta_reg;
  logic pinSync_reg;
  logic pinDly_reg;
  logic supMeta_reg;
  logic supSync_reg;
  logic rise;
  logic timeout;
  logic softDone;
  pcled_state_t state_reg;
  logic [4:0] count_reg;
  logic [13:0] lowCnt_reg;
  logic [12:0] ssCnt_reg;
  logic [4:0] swCnt_reg;

  // pin is asynchronous to sys_clk; only the second flop is read
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinMeta_reg <= 1'b0;
      pinSync_reg <= 1'b0;
    end else begin
      pinMeta_reg <= enSetPin;
      pinSync_reg <= pinMeta_reg;
    end
  end

  // previous pin sample; resets to the idle low so no false edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinDly_reg <= 1'b0;
    end else begin
      pinDly_reg <= pinSync_reg;
    end
  end

  // comparator output comes from the analog loop, unrelated to sys_clk
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      supMeta_reg <= 1'b0;
      supSync_reg <= 1'b0;
    end else begin
      supMeta_reg <= supplyAboveNeed;
      supSync_reg <= supMeta_reg;
    end
  end

  // 1 MHz pulses give 10 samples per phase, ample margin
  assign rise = pinSync_reg & ~pinDly_reg;
  // needs the pin low, so it never shares a cycle with a rise
  assign timeout = (lowCnt_reg == 14'(TOFF_CYC - 1)) & ~pinSync_reg;
  assign softDone = (ssCnt_reg == 13'(TSS_CYC - 1));

  // low-time counter restarts on any high sample, so short lows never disable
  always_ff @(posedge sys_clk) begin
    if (sys_rst || pinSync_reg || isOff(state_reg)) begin
      lowCnt_reg <= 14'h0000;
    end else if (!timeout) begin
      lowCnt_reg <= lowCnt_reg + 14'h0001;
    end
  end

  // pump phase: off, soft-starting, full capacity
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= PCLED_OFF;
    end else begin
      unique case (state_reg)
        PCLED_OFF: begin
          if (rise) begin
            state_reg <= PCLED_SOFT;
          end
        end
        PCLED_SOFT: begin
          if (timeout) begin
            state_reg <= PCLED_OFF;
          end else if (softDone) begin
            state_reg <= PCLED_ON;
          end
        end
        PCLED_ON: begin
          if (timeout) begin
            state_reg <= PCLED_OFF;
          end
        end
        default: state_reg <= PCLED_OFF;
      endcase
    end
  end

  // position in the table; the enabling edge itself lands on state 1
  always_ff @(posedge sys_clk) begin
    if (sys_rst || isOff(state_reg) || timeout) begin
      count_reg <= 5'h00;
    end else if (rise) begin
      // wraps 31->0 naturally: state 32 back to state 1
      count_reg <= count_reg + 5'h01;
    end
  end

  // soft-start timer, restarted by every enabling edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst || isOff(state_reg)) begin
      ssCnt_reg <= 13'h0000;
    end else if (state_reg == PCLED_SOFT && !softDone) begin
      ssCnt_reg <= ssCnt_reg + 13'h0001;
    end
  end

  // outputs registered; disabled shows zero current
  always_ff @(posedge sys_clk) begin
    if (sys_rst || isOff(state_reg)) begin
      ledLevel <= '0;
    end else begin
      ledLevel <= decodeLevel(count_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || isOff(state_reg)) begin
      deviceEnabled <= 1'b0;
    end else begin
      deviceEnabled <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pumpFullCapacity <= 1'b0;
    end else begin
      pumpFullCapacity <= (state_reg == PCLED_ON);
    end
  end

  // no hysteresis: a comparator that chatters moves the mode with it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || isOff(state_reg)) begin
      pumpDoubleMode <= 1'b0;
    end else begin
      pumpDoubleMode <= ~supSync_reg;
    end
  end

  // free-running fixed-rate pump clock, gated off while disabled
  always_ff @(posedge sys_clk) begin
    if (sys_rst || isOff(state_reg)) begin
      swCnt_reg <= 5'h00;
      pumpClk <= 1'b0;
    end else if (swCnt_reg == 5'(SW_HALF - 1)) begin
      swCnt_reg <= 5'h00;
      pumpClk <= ~pumpClk;
    end else begin
      swCnt_reg <= swCnt_reg + 5'h01;
    end
  end
endmodule

// ### src/pcled_consts.svh
// constants of the pulse-count led current interface
`ifndef PCLED_CONSTS_SVH
`define PCLED_CONSTS_SVH
`define PCLED_CLK_HZ 20000000
`define PCLED_TOFF_US 500
`define PCLED_TOFF_CYC ((`PCLED_TOFF_US * (`PCLED_CLK_HZ / 1000000)))
`define PCLED_SW_HZ 1000000
`define PCLED_SW_HALF_CYC (`PCLED_CLK_HZ / `PCLED_SW_HZ / 2)
`define PCLED_TSS_US 200
`define PCLED_TSS_CYC ((`PCLED_TSS_US * (`PCLED_CLK_HZ / 1000000)))
`define PCLED_STATES 32
`define PCLED_GROUP_LEN 6
`define PCLED_MA_0 5'h00
`define PCLED_MA_1 5'h01
`define PCLED_MA_10 5'h0A
`define PCLED_MA_12 5'h0C
`define PCLED_MA_15 5'h0F
`define PCLED_MA_20 5'h14
`endif

// ### src/pcled_pkg.sv
// types of the pulse-count led current interface
package pcled_pkg;
  typedef struct packed {
    logic [4:0] groupA; // led_group_a_outputs current, mA
    logic [4:0] groupB; // led_group_b_outputs current, mA
  } pcled_level_t;
  typedef enum logic [1:0] {
    PCLED_OFF = 2'b00,
    PCLED_SOFT = 2'b01,
    PCLED_ON = 2'b10
  } pcled_state_t;
endpackage

// ### test/pcled_ctrl_assertions.sv
// port assertions of the pulse-count led current interface
`timescale 1ns/1ps
module pcled_ctrl_chk (
  input logic sys_clk, // clock
  input logic sys_rst, // reset
  input logic enSetPin, // pin
  input logic supplyAboveNeed, // comparator
  input pcled_pkg::pcled_level_t ledLevel, // currents
  input logic deviceEnabled, // enabled
  input logic pumpFullCapacity, // pump ready
  input logic pumpDoubleMode, // 1.5X mode
  input logic pumpClk // pump clock
);
  import pcled_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_off_quiet:
  assert property (!deviceEnabled |-> ledLevel == '0 && !pumpClk && !pumpDoubleMode) else $error("active while off");
  a_enable_zero:
  assert property ($rose(deviceEnabled) |-> ledLevel == '0 && enSetPin) else $error("enable not at zero");
  a_hold_high:
  assert property (enSetPin [*8] |=> $stable(ledLevel)) else $error("level moved with pin high");
  a_low_short:
  assert property ($fell(enSetPin) && deviceEnabled |=> deviceEnabled [*8]) else $error("short low disabled");
  a_mode_follow:
  assert property (deviceEnabled |-> pumpDoubleMode == !$past(supplyAboveNeed, 3)) else $error("pump mode wrong");
  a_pclk_half:
  assert property ($fell(pumpClk) && deviceEnabled |-> $past(pumpClk, 10) && !$past(pumpClk, 11))
    else $error("pump clock high phase wrong");
  a_soft_wait:
  assert property ($rose(deviceEnabled) |-> !pumpFullCapacity [*8]) else $error("no soft-start");
  a_full_enabled:
  assert property (pumpFullCapacity |-> deviceEnabled) else $error("pump ready while off");
endmodule
bind pcled_ctrl pcled_ctrl_chk chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .enSetPin(enSetPin),
  .supplyAboveNeed(supplyAboveNeed), .ledLevel(ledLevel), .deviceEnabled(deviceEnabled),
  .pumpFullCapacity(pumpFullCapacity), .pumpDoubleMode(pumpDoubleMode), .pumpClk(pumpClk));

// ### test/pcled_host.sv
// host gpio model driving the enable/program pin
`timescale 1ns/1ps
module pcled_host (
  input logic clk, // clock
  output logic pin // enable/program pin
);
  initial pin = 1'b0;
  // ten cycles per phase keeps edges at 1 MHz
  task automatic pulse(input int n);
    repeat (n) begin
      pin <= 1'b0;
      repeat (10) @(negedge clk);
      pin <= 1'b1;
      repeat (10) @(negedge clk);
    end
  endtask
  task automatic rest(input int n);
    pin <= 1'b0;
    repeat (n) @(negedge clk);
  endtask
endmodule

// ### test/pcled_ctrl_tb.sv
// self-checking bench of the pulse-count led current interface
`timescale 1ns/1ps
`include "pcled_consts.svh"
module pcled_ctrl_tb;
  import pcled_pkg::*;
  logic sys_clk, sys_rst, enSetPin, supplyAboveNeed, deviceEnabled, pumpFullCapacity, pumpDoubleMode, pumpClk;
  pcled_level_t ledLevel;
  int fail_count = 0;
  int checks_done = 0;
  int enCycles = 0;
  logic [4:0] ma [6] = '{5'h00, 5'h01, 5'h0A, 5'h0C, 5'h0F, 5'h14};
  pcled_host host (.clk(sys_clk), .pin(enSetPin));
  pcled_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .enSetPin(enSetPin), .supplyAboveNeed(supplyAboveNeed),
    .ledLevel(ledLevel), .deviceEnabled(deviceEnabled), .pumpFullCapacity(pumpFullCapacity),
    .pumpDoubleMode(pumpDoubleMode), .pumpClk(pumpClk));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // negedges since deviceEnabled rose, to time the soft-start
  always @(negedge sys_clk) begin
    enCycles <= deviceEnabled ? enCycles + 1 : 0;
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // s counts from 0 for state 1; only state 32 breaks the six-step pattern
  function automatic pcled_level_t lvl(int s);
    lvl.groupA = (s == 31) ? 5'h14 : ma[s % 6];
    lvl.groupB = ma[s / 6];
  endfunction
  task automatic t_walk;
    for (int s = 0; s <= 32; s++) begin
      host.pulse(1);
      if (s == 0) begin
        chk("enabled", {15'h0000, deviceEnabled}, 16'h0001);
      end
      chk("level", {6'h00, ledLevel}, {6'h00, lvl(s % 32)});
    end
    $display("walk done");
  endtask
  task automatic t_timeout;
    host.rest(9995);
    chk("enabled", {15'h0000, deviceEnabled}, 16'h0001);
    host.rest(15);
    chk("enabled", {15'h0000, deviceEnabled}, 16'h0000);
    chk("level", {6'h00, ledLevel}, 16'h0000);
    chk("pump clk", {15'h0000, pumpClk}, 16'h0000);
    $display("timeout done");
  endtask
  task automatic t_burst;
    host.pulse(6);
    chk("level", {6'h00, ledLevel}, {6'h00, lvl(5)});
    chk("ready", {15'h0000, pumpFullCapacity}, 16'h0000);
    host.pulse(31);
    chk("level", {6'h00, ledLevel}, {6'h00, lvl(4)});
    $display("burst done");
  endtask
  task automatic t_mode;
    supplyAboveNeed <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("mode", {15'h0000, pumpDoubleMode}, 16'h0000);
    supplyAboveNeed <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("mode", {15'h0000, pumpDoubleMode}, 16'h0001);
    $display("mode done");
  endtask
  // bounded wait for the pump clock to reach a level, n counts the wait
  task automatic wait_pclk(input logic want, output int n);
    n = 0;
    while (pumpClk !== want) begin
      @(negedge sys_clk);
      n++;
      if (n > 40) begin
        fail_count++;
        print_verdict;
      end
    end
  endtask
  task automatic t_pump;
    int n;
    n = 0;
    while (pumpFullCapacity !== 1'b1) begin
      @(negedge sys_clk);
      n++;
      if (n > `PCLED_TSS_CYC) begin
        fail_count++;
        print_verdict;
      end
    end
    chk("soft time", 16'(enCycles), 16'(`PCLED_TSS_CYC));
    wait_pclk(1'b0, n);
    wait_pclk(1'b1, n);
    wait_pclk(1'b0, n);
    chk("pump half", 16'(n), 16'(`PCLED_SW_HALF_CYC));
    $display("pump done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    supplyAboveNeed = 1'b0;
    repeat (8) @(negedge sys_clk);
    sys_rst <= 1'b0;
    t_walk;
    t_timeout;
    t_burst;
    t_mode;
    t_pump;
    print_verdict;
  end
  initial begin
    #2000000;
    fail_count++;
    print_verdict;
  end
endmodule
